// File: verilog/itte_top.sv
// register slice: fast low count, fifo thresholds, controller enable
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "itte_consts.svh"
module itte_top
  import itte_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_core_clock,
  input wire itte_eng_t eng_i,
  input wire itte_fill_t fill_i,
  output logic [15:0] fast_scl_low_count,
  output logic use_fs_low_o,
  output logic eng_en_o,
  output logic rx_nack_o,
  output logic tx_flush_o,
  output logic rx_level_irq_o,
  output logic tx_level_irq_o,
  output logic irq_o
);

  // ***************************************************************
  // functions
  // ***************************************************************

  // known register offsets
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `ITTE_OFS_FS_LOW) || (a == `ITTE_OFS_RX_THR) ||
                 (a == `ITTE_OFS_TX_THR) || (a == `ITTE_OFS_ENABLE) ||
                 (a == `ITTE_OFS_STATUS) || (a == `ITTE_OFS_INT_STAT) ||
                 (a == `ITTE_OFS_INT_MASK);
  endfunction

  // clamp a written threshold to the deepest legal code
  function automatic logic [7:0] thr_clamp(input logic [7:0] v);
    thr_clamp = (v > `ITTE_THR_MAX) ? `ITTE_THR_MAX : v;
  endfunction

  // transmit code to entries: 0,1,2 as written, 3 is four
  function automatic logic [2:0] tx_entries(input logic [7:0] thr);
    tx_entries = (thr == `ITTE_THR_MAX) ? 3'h4 : thr[2:0];
  endfunction

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [7:0] rx_level_threshold;
  logic [7:0] tx_level_threshold;
  logic controller_enable_q;
  logic core_en_q;
  logic en_pend_q;
  logic [1:0] en_cnt_q;
  logic core_rise;
  itte_state_t state_q;
  itte_state_t state_d;
  logic flush_d;
  logic [2:0] int_stat_q;
  logic [2:0] int_stat_d;
  logic [2:0] int_mask_q;
  logic [2:0] int_set;
  logic rx_hit_d;
  logic tx_hit_d;
  logic acc;
  logic wr;
  logic [31:0] rd_d;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ***************************************************************
  // apb slave
  // ***************************************************************

  // one wait state; the write lands on the edge that sees pready
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  // read mux, unused bits read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `ITTE_OFS_FS_LOW: rd_d[15:0] = fast_scl_low_count;
      `ITTE_OFS_RX_THR: rd_d[7:0] = rx_level_threshold;
      `ITTE_OFS_TX_THR: rd_d[7:0] = tx_level_threshold;
      `ITTE_OFS_ENABLE: rd_d[`ITTE_BIT_ENABLE] = controller_enable_q;
      `ITTE_OFS_STATUS: rd_d[3:0] = {state_q == ITTE_DRAIN_RX || state_q == ITTE_DRAIN_TX,
                                     en_pend_q, eng_i.activity, core_en_q};
      `ITTE_OFS_INT_STAT: rd_d[2:0] = int_stat_q;
      `ITTE_OFS_INT_MASK: rd_d[2:0] = int_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // answer phase: pready, data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_d : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~addr_known(paddr);
    end
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************

  // fast low count with floor; thresholds clamped to buffer depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_scl_low_count <= `ITTE_RST_FS_LOW;
      rx_level_threshold <= `ITTE_RST_RX_THR;
      tx_level_threshold <= `ITTE_RST_TX_THR;
      int_mask_q <= `ITTE_RST_INT_MASK;
    end else if (wr) begin
      if (paddr == `ITTE_OFS_FS_LOW) begin
        fast_scl_low_count <= (pwdata[15:0] < `ITTE_MIN_FS_LOW) ? `ITTE_MIN_FS_LOW : pwdata[15:0];
      end
      if (paddr == `ITTE_OFS_RX_THR) begin
        rx_level_threshold <= thr_clamp(pwdata[7:0]);
      end
      if (paddr == `ITTE_OFS_TX_THR) begin
        tx_level_threshold <= thr_clamp(pwdata[7:0]);
      end
      if (paddr == `ITTE_OFS_INT_MASK) begin
        int_mask_q <= pwdata[2:0];
      end
    end
  end

  // fast count selected in fast mode and for the hs preamble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_fs_low_o <= 1'b1;
    end else begin
      use_fs_low_o <= ~eng_i.hs_mode | eng_i.hs_preamble;
    end
  end

  // ***************************************************************
  // enable with core clock delay
  // ***************************************************************
  itte_clk_edge u_core_edge (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(serial_core_clock),
    .rise_q(core_rise)
  );

  // software copy of the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_enable_q <= 1'b0;
    end else if (wr && paddr == `ITTE_OFS_ENABLE) begin
      controller_enable_q <= pwdata[`ITTE_BIT_ENABLE];
    end
  end

  // effective enable follows after two core clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_pend_q <= 1'b0;
      en_cnt_q <= 2'h0;
      core_en_q <= 1'b0;
    end else if (wr && paddr == `ITTE_OFS_ENABLE) begin
      en_pend_q <= 1'b1;
      en_cnt_q <= 2'h0;
    end else if (en_pend_q && core_rise) begin
      if (en_cnt_q == `ITTE_EN_DELAY - 2'h1) begin
        core_en_q <= controller_enable_q;
        en_pend_q <= 1'b0;
        en_cnt_q <= 2'h0;
      end else begin
        en_cnt_q <= en_cnt_q + 2'h1;
      end
    end
  end

  // ***************************************************************
  // controller on, off and drain
  // ***************************************************************

  // next state; drains end only at the transfer or byte boundary
  always_comb begin
    state_d = state_q;
    flush_d = 1'b0;
    unique case (state_q)
      ITTE_OFF: begin
        if (core_en_q) begin
          state_d = ITTE_ON;
        end
      end
      ITTE_ON: begin
        if (!core_en_q) begin
          // a done pulse in this very cycle already ends the transfer, so no drain
          if (eng_i.activity && eng_i.xfer_tx && !eng_i.tx_done) begin
            state_d = ITTE_DRAIN_TX;
          end else if (eng_i.activity && !eng_i.xfer_tx && !eng_i.rx_byte_done) begin
            state_d = ITTE_DRAIN_RX;
          end else begin
            state_d = ITTE_OFF;
            flush_d = 1'b1;
          end
        end
      end
      ITTE_DRAIN_TX: begin
        if (eng_i.tx_done) begin
          state_d = ITTE_OFF;
          flush_d = 1'b1;
        end
      end
      ITTE_DRAIN_RX: begin
        if (eng_i.rx_byte_done) begin
          state_d = ITTE_OFF;
          flush_d = 1'b1;
        end
      end
    endcase
  end

  // state and registered engine controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ITTE_OFF;
      eng_en_o <= 1'b0;
      rx_nack_o <= 1'b0;
      tx_flush_o <= 1'b0;
    end else begin
      state_q <= state_d;
      eng_en_o <= (state_d == ITTE_ON) | (state_d == ITTE_DRAIN_TX);
      rx_nack_o <= (state_d == ITTE_DRAIN_RX);
      tx_flush_o <= flush_d;
    end
  end

  // ***************************************************************
  // level interrupts and status
  // ***************************************************************
  assign rx_hit_d = {1'b0, fill_i.rx_level} >= (rx_level_threshold[3:0] + 4'h1);
  assign tx_hit_d = fill_i.tx_level <= tx_entries(tx_level_threshold);

  // sticky bits set on level rise, off bit on the flush; set wins over write-one-clear
  always_comb begin
    int_set = 3'h0;
    int_set[`ITTE_INT_RX] = rx_hit_d & ~rx_level_irq_o;
    int_set[`ITTE_INT_TX] = tx_hit_d & ~tx_level_irq_o;
    int_set[`ITTE_INT_OFF] = flush_d;
    int_stat_d = int_stat_q;
    if (wr && paddr == `ITTE_OFS_INT_STAT) begin
      int_stat_d = int_stat_d & ~pwdata[2:0];
    end
    int_stat_d = int_stat_d | int_set;
  end

  // level outputs and combined interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_level_irq_o <= 1'b0;
      tx_level_irq_o <= 1'b0;
      int_stat_q <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      rx_level_irq_o <= rx_hit_d;
      tx_level_irq_o <= tx_hit_d;
      int_stat_q <= int_stat_d;
      irq_o <= |(int_stat_d & int_mask_q);
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  sequence s_fs_write;
    wr && paddr == `ITTE_OFS_FS_LOW;
  endsequence

  property p_fs_floor;
    s_fs_write |=> fast_scl_low_count >= `ITTE_MIN_FS_LOW &&
      (fast_scl_low_count == $past(pwdata[15:0]) || $past(pwdata[15:0]) < `ITTE_MIN_FS_LOW);
  endproperty
  a_fs_floor: assert property (p_fs_floor) else $error("fast low count below floor");

  property p_fs_hold;
    !(wr && paddr == `ITTE_OFS_FS_LOW) |=> $stable(fast_scl_low_count);
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("fast low count changed without write");

  property p_hs_sel;
    eng_i.hs_mode && !eng_i.hs_preamble |=> !use_fs_low_o;
  endproperty
  a_hs_sel: assert property (p_hs_sel) else $error("fast count used outside preamble");

  property p_rx_clamp;
    wr && paddr == `ITTE_OFS_RX_THR && pwdata[7:0] > `ITTE_THR_MAX |=> rx_level_threshold == `ITTE_THR_MAX;
  endproperty
  a_rx_clamp: assert property (p_rx_clamp) else $error("receive threshold not clamped");

  property p_tx_clamp;
    wr && paddr == `ITTE_OFS_TX_THR && pwdata[7:0] > `ITTE_THR_MAX |=> tx_level_threshold == `ITTE_THR_MAX;
  endproperty
  a_tx_clamp: assert property (p_tx_clamp) else $error("transmit threshold not clamped");

  property p_rx_level;
    {1'b0, fill_i.rx_level} > rx_level_threshold[3:0] |=> rx_level_irq_o;
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive level missed");

  property p_tx_level;
    tx_level_threshold == `ITTE_THR_MAX && fill_i.tx_level == 3'h4 |=> tx_level_irq_o;
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("transmit level missed at four");

  property p_en_delay;
    $changed(core_en_q) |-> $past(en_pend_q) && $past(core_rise) && $past(en_cnt_q) == 2'h1;
  endproperty
  a_en_delay: assert property (p_en_delay) else $error("enable applied early");

  sequence s_drain_tx_done;
    state_q == ITTE_DRAIN_TX && eng_i.tx_done;
  endsequence

  property p_tx_flush;
    s_drain_tx_done |=> tx_flush_o && !eng_en_o;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("no flush after drained transfer");

  property p_rx_nack;
    state_q == ITTE_ON && !core_en_q && eng_i.activity && !eng_i.xfer_tx && !eng_i.rx_byte_done |=>
      rx_nack_o until eng_i.rx_byte_done;
  endproperty
  a_rx_nack: assert property (p_rx_nack) else $error("receive byte not refused");

  property p_en_reg;
    wr && paddr == `ITTE_OFS_ENABLE |=> controller_enable_q == $past(pwdata[0]);
  endproperty
  a_en_reg: assert property (p_en_reg) else $error("enable bit not stored");

endmodule

// File: verilog/itte_consts.svh
// constants for the bus controller timing, threshold and enable slice
`ifndef ITTE_CONSTS_SVH
`define ITTE_CONSTS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define ITTE_OFS_FS_LOW 8'h00
`define ITTE_OFS_RX_THR 8'h04
`define ITTE_OFS_TX_THR 8'h08
`define ITTE_OFS_ENABLE 8'h0C
`define ITTE_OFS_STATUS 8'h10
`define ITTE_OFS_INT_STAT 8'h14
`define ITTE_OFS_INT_MASK 8'h18

// ***************************************************************
// reset values and limits
// ***************************************************************
`define ITTE_RST_FS_LOW 16'h0022
`define ITTE_MIN_FS_LOW 16'h0008
`define ITTE_RST_RX_THR 8'h02
`define ITTE_RST_TX_THR 8'h01
`define ITTE_THR_MAX 8'h03
`define ITTE_RST_INT_MASK 3'h0
`define ITTE_EN_DELAY 2'h2

// ***************************************************************
// field positions
// ***************************************************************
`define ITTE_BIT_ENABLE 0
`define ITTE_INT_RX 0
`define ITTE_INT_TX 1
`define ITTE_INT_OFF 2

`endif

// File: verilog/itte_pkg.sv
// types shared by the timing, threshold and enable slice
package itte_pkg;

  // controller state, gray along off -> on -> drain tx; on -> drain rx flips both bits
  typedef enum logic [1:0] {
    ITTE_OFF = 2'h0,
    ITTE_ON = 2'h1,
    ITTE_DRAIN_TX = 2'h3,
    ITTE_DRAIN_RX = 2'h2
  } itte_state_t;

  // status from the transfer engine, same clock
  typedef struct packed {
    logic activity;
    logic xfer_tx;
    logic tx_done;
    logic rx_byte_done;
    logic hs_mode;
    logic hs_preamble;
  } itte_eng_t;

  // fifo fill levels, 0 to 4 entries
  typedef struct packed {
    logic [2:0] rx_level;
    logic [2:0] tx_level;
  } itte_fill_t;

endpackage

// File: verilog/itte_clk_edge.sv
// synchroniser and rising edge finder for the sampled core clock
`timescale 1ns/100ps
module itte_clk_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise_q
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // two flops, then edge detect on the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= sync_q & ~last_q;
    end
  end

endmodule

// File: tb/itte_eng_model.sv
// far-side transfer engine and free running serial core clock model
`timescale 1ns/100ps
module itte_eng_model
  import itte_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go_tx,
  input wire logic go_rx,
  input wire logic hs_mode,
  input wire logic hs_pre,
  output itte_eng_t eng,
  output logic core_clk
);
  logic [5:0] cnt_q;
  logic dir_q;

  // ****************************************
  // clock and transfer timing
  // ****************************************
  // core clock period 160 ns, unrelated to pclk
  initial begin
    core_clk = 1'b0;
    #37;
    forever #80 core_clk = ~core_clk;
  end

  // a transfer lasts 63 cycles so that a disable lands in mid-transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      dir_q <= 1'b0;
    end else if (go_tx || go_rx) begin
      cnt_q <= 6'h3F;
      dir_q <= go_tx;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end
  end

  // done pulse in the last busy cycle
  always_comb begin
    eng.activity = (cnt_q != 6'h00);
    eng.xfer_tx = dir_q;
    eng.tx_done = (cnt_q == 6'h01) && dir_q;
    eng.rx_byte_done = (cnt_q == 6'h01) && !dir_q;
    eng.hs_mode = hs_mode;
    eng.hs_preamble = hs_pre;
  end
endmodule

// File: tb/i2c_timing_threshold_enable_tb_top.sv
// testbench for the timing, threshold and enable slice
`timescale 1ns/100ps
`include "itte_consts.svh"
module i2c_timing_threshold_enable_tb_top
  import itte_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_clk;
  logic go_tx, go_rx, hs, pre, use_fs, en, nack, flush, rxi, txi, irq;
  logic en_at_done, nack_at_done, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] fsl;
  itte_eng_t eng;
  itte_fill_t fill;
  int err_count, tests_run, flushes, f0;

  itte_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_core_clock(core_clk), .eng_i(eng), .fill_i(fill), .fast_scl_low_count(fsl),
    .use_fs_low_o(use_fs), .eng_en_o(en), .rx_nack_o(nack), .tx_flush_o(flush),
    .rx_level_irq_o(rxi), .tx_level_irq_o(txi), .irq_o(irq));

  itte_eng_model i_model (.pclk(pclk), .presetn(presetn), .go_tx(go_tx), .go_rx(go_rx),
    .hs_mode(hs), .hs_pre(pre), .eng(eng), .core_clk(core_clk));

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // count flush pulses and note the outputs at each end of transfer
  always @(posedge pclk) begin
    if (flush === 1'b1) flushes++;
    if (eng.tx_done === 1'b1 || eng.rx_byte_done === 1'b1) begin
      en_at_done = en;
      nack_at_done = nack;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one apb transfer, answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 0, 1);
    rdata = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait whole cycles; outputs read here were launched at earlier edges
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    apb(0, `ITTE_OFS_FS_LOW, 0); chk("fs reset", rdata, 32'h22);
    apb(0, `ITTE_OFS_RX_THR, 0); chk("rx reset", rdata, 32'h2);
    apb(0, `ITTE_OFS_TX_THR, 0); chk("tx reset", rdata, 32'h1);
    apb(0, `ITTE_OFS_ENABLE, 0); chk("en reset", rdata, 32'h0);
    apb(0, `ITTE_OFS_INT_MASK, 0); chk("mask reset", rdata, 32'h0);
  endtask

  // low writes clamp to the minimum of 8, larger values stay
  task automatic t_fast();
    logic [15:0] wv[5] = '{16'h0000, 16'h0005, 16'h0007, 16'h0008, 16'h1234};
    logic [15:0] ev[5] = '{16'h0008, 16'h0008, 16'h0008, 16'h0008, 16'h1234};
    for (int i = 0; i < 5; i++) begin
      apb(1, `ITTE_OFS_FS_LOW, {16'h0000, wv[i]});
      apb(0, `ITTE_OFS_FS_LOW, 0);
      chk("fs low", rdata, {16'h0000, ev[i]});
    end
    chk("fs port", fsl, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      hs <= i[1];
      pre <= i[0];
      settle(3);
      chk("use fs", use_fs, !i[1] || i[0]);
    end
  endtask

  task automatic t_thr();
    for (int t = 0; t < 4; t++) begin
      apb(1, `ITTE_OFS_RX_THR, t);
      apb(1, `ITTE_OFS_TX_THR, t);
      for (int f = 0; f < 5; f++) begin
        fill <= '{rx_level: f[2:0], tx_level: f[2:0]};
        settle(3);
        chk("rx level", rxi, f >= t + 1);
        chk("tx level", txi, f <= ((t == 3) ? 4 : t));
      end
    end
    apb(1, `ITTE_OFS_RX_THR, 9);
    apb(0, `ITTE_OFS_RX_THR, 0); chk("rx clamp", rdata, 32'h3);
    apb(1, `ITTE_OFS_TX_THR, 255);
    apb(0, `ITTE_OFS_TX_THR, 0); chk("tx clamp", rdata, 32'h3);
  endtask

  // masked, unmasked and cleared receive level event, unmapped place
  task automatic t_irq();
    fill <= '{rx_level: 3'h0, tx_level: 3'h0};
    settle(3);
    apb(1, `ITTE_OFS_INT_STAT, 7);
    fill <= '{rx_level: 3'h4, tx_level: 3'h0};
    settle(3);
    chk("irq masked", irq, 0);
    apb(0, `ITTE_OFS_INT_STAT, 0); chk("rx event", rdata[0], 1);
    apb(1, `ITTE_OFS_INT_MASK, 1);
    settle(2); chk("irq on", irq, 1);
    apb(1, `ITTE_OFS_INT_STAT, 7);
    settle(2); chk("irq clear", irq, 0);
    apb(1, 8'h1C, 32'hFFFF); chk("wr err", err_seen, 1);
    apb(0, 8'h1C, 0); chk("rd err", err_seen, 1);
    chk("rd zero", rdata, 0);
  endtask

  task automatic t_enable();
    apb(1, `ITTE_OFS_ENABLE, 1);
    apb(0, `ITTE_OFS_STATUS, 0); chk("en early", rdata[0], 0);
    settle(60);
    apb(0, `ITTE_OFS_STATUS, 0); chk("en late", rdata[0], 1);
    chk("eng en", en, 1);
  endtask

  // disable when idle, after polling the activity bit
  task automatic t_idle_off();
    apb(1, `ITTE_OFS_INT_STAT, 7);
    apb(1, `ITTE_OFS_INT_MASK, 4);
    apb(0, `ITTE_OFS_STATUS, 0); chk("idle", rdata[1], 0);
    f0 = flushes;
    apb(1, `ITTE_OFS_ENABLE, 0);
    settle(60);
    chk("idle flush", flushes - f0, 1);
    chk("off", en, 0);
    chk("irq off", irq, 1);
    apb(1, `ITTE_OFS_INT_STAT, 4);
    settle(2); chk("irq off clr", irq, 0);
  endtask

  // disable in mid-transfer of either direction
  task automatic t_drain(input logic tx);
    t_enable();
    go_tx <= tx;
    go_rx <= !tx;
    @(posedge pclk);
    go_tx <= 1'b0;
    go_rx <= 1'b0;
    f0 = flushes;
    apb(1, `ITTE_OFS_ENABLE, 0);
    settle(90);
    chk("en at done", en_at_done, tx);
    chk("nack at done", nack_at_done, !tx);
    chk("drain flush", flushes - f0, 1);
    chk("drained", {en, nack}, 0);
  endtask

  initial begin
    #300us;
    err_count++;
    results();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go_tx, go_rx, hs, pre} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    fill = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fast();
    t_thr();
    t_irq();
    t_enable();
    t_idle_off();
    t_drain(1'b1);
    t_drain(1'b0);
    results();
  end
endmodule
